/* dv/lsd_props.sv */
`timescale 1ns/1ns
// Port-level checks of the supply monitor control block.
module lsd_props import lsd_pkg::*; (
  input wire logic clk_in, // System clock.
  input wire logic rst_in, // Synchronous reset.
  input wire logic por_in, // Power-on kind of reset.
  input wire logic trip_async_in, // Comparator output.
  input wire logic ref_stable_async_in, // Reference settled.
  input wire logic sleep_in, // Device asleep.
  input wire logic s_axi_arvalid_in, // Read request.
  input wire logic s_axi_arready_out, // Read request taken.
  input wire logic s_axi_rvalid_out, // Read answer.
  input wire lsd_analog_t analog_out, // Analog controls.
  input wire logic irq_out, // Interrupt level.
  input wire logic irq_high_prio_out, // Interrupt priority.
  input wire logic wake_out // Wake request.
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Four samples cover both synchronisers plus the flag register.
  sequence s_trip_held;
    (trip_async_in && ref_stable_async_in && analog_out.power_up && sleep_in)[*4];
  endsequence
  sequence s_reset_done;
    !rst_in && $past(rst_in);
  endsequence
  a_trip_wakes: assert property (s_trip_held |-> wake_out)
    else $error("trip while asleep gave no wake");
  a_wake_asleep: assert property (wake_out |-> sleep_in)
    else $error("wake without sleep");
  a_ext_route: assert property (
    analog_out.use_external == (analog_out.tap_sel == LSD_LVL_EXT))
    else $error("external route mismatch");
  a_reset_off: assert property (s_reset_done |-> !analog_out.power_up
    && analog_out.tap_sel == LSD_CTRL_RST[3:0])
    else $error("detector not off after reset");
  a_prio_reset: assert property (s_reset_done |-> irq_high_prio_out == $past(por_in))
    else $error("priority reset value wrong");
  a_irq_reset: assert property (s_reset_done |-> !irq_out && !wake_out)
    else $error("request live after reset");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered next cycle");
  a_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while answer pending");
endmodule // lsd_props

/* dv/tb_low_supply_detect_control.sv */
`timescale 1ns/1ns
module tb_low_supply_detect_control import lsd_pkg::*; ;
  logic clk_in = 1'b0, rst_in = 1'b1, por_in = 1'b1, trip_async_in = 1'b0, sleep_in = 1'b0;
  logic ref_stable_async_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0, s_axi_wstrb_in = 4'hf;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic irq_out, irq_high_prio_out, wake_out;
  lsd_analog_t analog_out;
  logic [33:0] q[$];
  logic [7:0] lf = 8'h17;
  int fails = 0, checks = 0;
  lsd_top dut_u (.clk_in, .rst_in, .por_in, .trip_async_in, .ref_stable_async_in, .sleep_in,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .analog_out, .irq_out, .irq_high_prio_out, .wake_out);
  // The 100 MHz system clock.
  initial forever #5 clk_in = ~clk_in;
  function automatic logic [33:0] ok(input logic [7:0] d);
    return {26'h0, d};
  endfunction
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Address and data go out together; each is dropped once the slave has taken it.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    forever begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out) break;
    end
    s_axi_bready_in <= 1'b0;
  endtask
  // The expected answer is queued before the request leaves.
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    q.push_back(e);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    forever begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out) break;
    end
    s_axi_rready_in <= 1'b0;
  endtask
  // Every read answer is matched against the oldest queued expectation.
  always @(posedge clk_in) if (s_axi_rvalid_out && s_axi_rready_in) chk({s_axi_rresp_out,
    s_axi_rdata_out}, q.pop_front());
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(LSD_OFF_CTRL, ok(LSD_CTRL_RST));
    rd(LSD_OFF_FLAGS, ok(8'h00));
    rd(LSD_OFF_ENABLES, ok(8'h00));
    rd(LSD_OFF_PRIO, ok(LSD_PRIO_POR_RST));
    // Top bits are written high on every code to show they stay dead.
    for (int i = 0; i < 16; i++) begin
      wr(LSD_OFF_CTRL, 8'hd0 | i[7:0]);
      rd(LSD_OFF_CTRL, ok(8'h30 | i[7:0]));
      chk({28'h0, analog_out}, {28'h0, i[3:0], i == 15, 1'b1});
    end
    ref_stable_async_in <= 1'b0;
    wr(LSD_OFF_CTRL, 8'h15);
    trip_async_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    trip_async_in <= 1'b0;
    rd(LSD_OFF_FLAGS, ok(8'h00));
    rd(LSD_OFF_CTRL, ok(8'h15));
    ref_stable_async_in <= 1'b1;
    wr(LSD_OFF_FLAGS, 8'h00);
    wr(LSD_OFF_ENABLES, 8'h04);
    sleep_in <= 1'b1;
    trip_async_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    trip_async_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk({32'h0, irq_out, wake_out}, 34'h3);
    rd(LSD_OFF_FLAGS, ok(8'h04));
    sleep_in <= 1'b0;
    wr(LSD_OFF_FLAGS, 8'h00);
    rd(LSD_OFF_FLAGS, ok(8'h00));
    chk({33'h0, irq_out}, 34'h0);
    repeat (4) begin
      lf = nx(lf);
      wr(LSD_OFF_PRIO, lf);
      rd(LSD_OFF_PRIO, ok(lf & LSD_P2_WMASK));
      chk({33'h0, irq_high_prio_out}, {33'h0, lf[2]});
    end
    rd(4'h2, {LSD_RESP_SLVERR, 32'h0});
    por_in <= 1'b0;
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(LSD_OFF_PRIO, ok(LSD_PRIO_OTHER_RST));
    rd(LSD_OFF_CTRL, ok(LSD_CTRL_RST));
    finish_test;
  end
  // A hang counts as a mismatch; the run needs only a few hundred cycles.
  initial begin
    #200000;
    fails++;
    finish_test;
  end
endmodule // tb_low_supply_detect_control
bind lsd_top lsd_props u_props (.clk_in, .rst_in, .por_in, .trip_async_in, .ref_stable_async_in,
  .sleep_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .analog_out, .irq_out,
  .irq_high_prio_out, .wake_out);

/* hw/lsd_pkg.sv */
// Operation
// R1: Comparator trip, supply below set point, sets the low-supply flag.
// R2: Flag set with its enable set raises the interrupt request.
// R3: Four-bit trip-level select in control bits 3:0, sixteen codes.
// R4: Code all ones routes the comparator from the external trip input.
// R5: Codes 0001 to 1110 pick internal taps; code 0000 is reserved.
// R6: Read-only reference-stable flag at bit 5 shows the detector is valid.
// R7: Software keeps the interrupt disabled while reference-stable reads zero.
// R8: Power-enable bit 4 powers the detector up when set, down when clear.
// R9: Control bits 7 and 6 ignore writes and read as zero.
// R10: Low-supply flag is bit 2 of the second flag register, resets zero.
// R11: Low-supply enable is bit 2 of the second enable register, resets zero.
// R12: Priority bit 2; register resets all ones on power-on, else 1 0000.
// R13: Flag setting is suppressed until the reference is stable after enable.
// R14: Software selects level, enables, waits stable, clears flag, then enables.
// R15: The detector keeps running in sleep and a trip wakes the device.
// R16: Any reset returns the control register to reset, turning detector off.
// R17: Comparator and stable inputs pass a two-stage synchroniser first.
// R18: The flag stays set until software writes zero to it.
package lsd_pkg;
  localparam logic [3:0] LSD_OFF_CTRL = 4'h0;
  localparam logic [3:0] LSD_OFF_FLAGS = 4'h4;
  localparam logic [3:0] LSD_OFF_ENABLES = 4'h8;
  localparam logic [3:0] LSD_OFF_PRIO = 4'hc;
  localparam logic [3:0] LSD_OFF_STATUS = 4'h0;
  localparam int LSD_BIT_STABLE = 5;
  localparam int LSD_BIT_POWER = 4;
  localparam int LSD_BIT_LOW = 2;
  localparam logic [7:0] LSD_CTRL_RST = 8'h05;
  localparam logic [7:0] LSD_CTRL_WMASK = 8'h1f;
  localparam logic [7:0] LSD_FLAGS_RST = 8'h00;
  localparam logic [7:0] LSD_P2_WMASK = 8'h1f;
  localparam logic [7:0] LSD_PRIO_POR_RST = 8'h1f;
  localparam logic [7:0] LSD_PRIO_OTHER_RST = 8'h10;
  localparam logic [3:0] LSD_LVL_EXT = 4'hf;
  localparam logic [3:0] LSD_LVL_RSVD = 4'h0;
  localparam logic [1:0] LSD_RESP_OKAY = 2'b00;
  localparam logic [1:0] LSD_RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic [3:0] tap_sel;
    logic use_external;
    logic power_up;
  } lsd_analog_t;
endpackage

/* hw/lsd_top.sv */
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module lsd_top import lsd_pkg::*; (
  input wire logic clk_in, // System clock, 100 MHz.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic por_in, // High with rst_in when the reset is power-on or brown-out.
  input wire logic trip_async_in, // Comparator output, high when below set point.
  input wire logic ref_stable_async_in, // Reference settled indication from analog.
  input wire logic sleep_in, // Device is asleep.
  input wire logic [3:0] s_axi_awaddr_in, // Write address.
  input wire logic s_axi_awvalid_in, // Write address valid.
  output logic s_axi_awready_out, // Write address ready.
  input wire logic [31:0] s_axi_wdata_in, // Write data.
  input wire logic [3:0] s_axi_wstrb_in, // Write byte strobes.
  input wire logic s_axi_wvalid_in, // Write data valid.
  output logic s_axi_wready_out, // Write data ready.
  output logic [1:0] s_axi_bresp_out, // Write response.
  output logic s_axi_bvalid_out, // Write response valid.
  input wire logic s_axi_bready_in, // Write response ready.
  input wire logic [3:0] s_axi_araddr_in, // Read address.
  input wire logic s_axi_arvalid_in, // Read address valid.
  output logic s_axi_arready_out, // Read address ready.
  output logic [31:0] s_axi_rdata_out, // Read data.
  output logic [1:0] s_axi_rresp_out, // Read response.
  output logic s_axi_rvalid_out, // Read data valid.
  input wire logic s_axi_rready_in, // Read data ready.
  output lsd_analog_t analog_out, // Tap select and power controls to the analog part.
  output logic irq_out, // Interrupt request level.
  output logic irq_high_prio_out, // Priority of the request, high when set.
  output logic wake_out // Wake request from sleep.
);
  logic [7:0] ctrl_r;
  logic [7:0] flags_r;
  logic [7:0] enables_r;
  logic [7:0] prio_r;
  logic [1:0] trip_sync_r;
  logic [1:0] stable_sync_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic wr_fire;
  logic wr_flag_clr;
  logic ref_stable;
  logic trip_event;
  logic [7:0] rd_val;
  logic rd_ok;

  // Mapped offsets; other addresses answer with an error.
  function automatic logic lsd_mapped(input logic [3:0] addr);
    return addr == LSD_OFF_CTRL || addr == LSD_OFF_FLAGS ||
           addr == LSD_OFF_ENABLES || addr == LSD_OFF_PRIO;
  endfunction

  // Two flops; only the second stage is looked at by any logic.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trip_sync_r <= 2'b00;
      stable_sync_r <= 2'b00;
    end else begin
      trip_sync_r <= {trip_sync_r[0], trip_async_in}; // [R17]
      stable_sync_r <= {stable_sync_r[0], ref_stable_async_in}; // [R17]
    end
  end

  // A powered-down detector can never claim a stable reference.
  assign ref_stable = stable_sync_r[1] & ctrl_r[LSD_BIT_POWER]; // [R6] [R13]
  // The detector runs regardless of sleep_in, so trips still land while asleep.
  assign trip_event = trip_sync_r[1] & ref_stable; // [R1] [R13] [R15]

  // Analog controls; the tap select passes through, code 0000 reserved.
  always_comb begin
    analog_out.tap_sel = ctrl_r[3:0]; // [R3] [R5]
    analog_out.use_external = ctrl_r[3:0] == LSD_LVL_EXT; // [R4]
    analog_out.power_up = ctrl_r[LSD_BIT_POWER]; // [R8]
  end

  // Write address and data are caught separately, in either order.
  assign s_axi_awready_out = !aw_hold_r && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_hold_r && !s_axi_bvalid_out;
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid_out;
  assign wr_flag_clr = wr_fire && wstrb0_r && awaddr_r == LSD_OFF_FLAGS;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= LSD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb0_r <= s_axi_wstrb_in[0];
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= lsd_mapped(awaddr_r) ? LSD_RESP_OKAY : LSD_RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Control register; bits 7:6 and 5 are never stored.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= LSD_CTRL_RST; // [R16]
    end else if (wr_fire && wstrb0_r && awaddr_r == LSD_OFF_CTRL) begin
      ctrl_r <= wdata_r[7:0] & LSD_CTRL_WMASK; // [R9] [R3] [R8]
    end
  end

  // Only the low-supply bit lives here; the set beats a same-cycle clear.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_r <= LSD_FLAGS_RST; // [R10]
    end else begin
      if (wr_flag_clr && !wdata_r[LSD_BIT_LOW]) begin
        flags_r[LSD_BIT_LOW] <= 1'b0; // [R18]
      end
      if (trip_event) begin
        flags_r[LSD_BIT_LOW] <= 1'b1; // [R1]
      end
    end
  end

  // Enable and priority registers hold the peripheral bits 4:0.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enables_r <= LSD_FLAGS_RST; // [R11]
      prio_r <= por_in ? LSD_PRIO_POR_RST : LSD_PRIO_OTHER_RST; // [R12]
    end else if (wr_fire && wstrb0_r) begin
      if (awaddr_r == LSD_OFF_ENABLES) begin
        enables_r <= wdata_r[7:0] & LSD_P2_WMASK; // [R11]
      end
      if (awaddr_r == LSD_OFF_PRIO) begin
        prio_r <= wdata_r[7:0] & LSD_P2_WMASK; // [R12]
      end
    end
  end

  // Interrupt is a level while flag and enable are both set.
  assign irq_out = flags_r[LSD_BIT_LOW] & enables_r[LSD_BIT_LOW]; // [R2]
  assign irq_high_prio_out = prio_r[LSD_BIT_LOW]; // [R12]
  // A set flag wakes the core even with the interrupt masked.
  assign wake_out = flags_r[LSD_BIT_LOW] & sleep_in; // [R15]

  // Read mux; the stable bit is assembled live, not stored.
  always_comb begin
    rd_val = 8'h00;
    rd_ok = lsd_mapped(s_axi_araddr_in);
    unique case (s_axi_araddr_in)
      LSD_OFF_CTRL: rd_val = {2'b00, ref_stable, ctrl_r[4:0]}; // [R6] [R9]
      LSD_OFF_FLAGS: rd_val = flags_r;
      LSD_OFF_ENABLES: rd_val = enables_r;
      LSD_OFF_PRIO: rd_val = prio_r;
      default: rd_val = 8'h00;
    endcase
  end

  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= LSD_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h0, rd_val};
      s_axi_rresp_out <= rd_ok ? LSD_RESP_OKAY : LSD_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
endmodule // lsd_top
